/* File: shared/dramx4_pkg.sv */
// Constants and carrier types for the page-mode DRAM controller.
// Assumes a 20 MHz system clock; all timing counts derive from it.
package dramx4_pkg;
  localparam int CLK_MHZ = 20;
  localparam int CLK_NS = 50;
  // Strobe timing in ns, converted to cycles (least times round up)
  localparam int ROW_PRECHARGE_NS = 60;
  localparam int ROW_PRE_CYC = (ROW_PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ROW_TO_COL_NS = 50;
  localparam int ROW_COL_CYC = (ROW_TO_COL_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_NS = 80;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int ROW_ACTIVE_NS = 80;
  localparam int ROW_ACT_CYC = (ROW_ACTIVE_NS + CLK_NS - 1) / CLK_NS;
  // Power-up pause in us and init cycle count
  localparam int POWERUP_US = 200;
  localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
  localparam int INIT_CYCLES = 8;
  // Refresh period per variant, in ms, and row counts
  localparam int REF_MS_4K = 64;
  localparam int REF_MS_2K = 32;
  localparam int ROWS_4K = 4096;
  localparam int ROWS_2K = 2048;
  // Cycles between refreshes: period / rows, rounded down
  localparam int REF_INT_4K = (REF_MS_4K * 1000 * CLK_MHZ * 1000) / ROWS_4K
    / 1000;
  localparam int REF_INT_2K = (REF_MS_2K * 1000 * CLK_MHZ * 1000) / ROWS_2K
    / 1000;
  localparam int ADDR_W = 22;
  localparam int PIN_W = 12;
  localparam int DATA_W = 4;

  typedef enum logic [1:0] {
    DRX_OP_READ,
    DRX_OP_WRITE,
    DRX_OP_RMW
  } dramx4_op_t;

  typedef struct packed {
    dramx4_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dramx4_req_t;

  typedef struct packed {
    logic rasN;
    logic casN;
    logic wN;
    logic oeN;
    logic [PIN_W-1:0] addr;
  } dramx4_pins_t;
endpackage

/* File: rtl/dramx4_ctrl.sv */
// Host-side controller for an asynchronous 4M x 4 page-mode DRAM.
// Assumes the DRAM sits on pins driven from flops clocked by clk; read
// data returns through a two-flop synchroniser.
`timescale 1ns/10ps
module dramx4_ctrl #(
  parameter bit ROWS_4K_MODE = 1'b1,
  parameter int POWERUP_CYCLES = dramx4_pkg::POWERUP_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire dramx4_pkg::dramx4_req_t reqData,
  input wire logic reqValid,
  output logic reqReady,
  output logic [dramx4_pkg::DATA_W-1:0] rdData,
  output logic rdValid,
  output logic initDone,
  output dramx4_pkg::dramx4_pins_t pinOut,
  output logic [dramx4_pkg::DATA_W-1:0] dqOut,
  output logic dqOe,
  input wire logic [dramx4_pkg::DATA_W-1:0] dqIn
);
  typedef enum logic [3:0] {
    ST_POWERUP, ST_IDLE, ST_ROW, ST_COL, ST_WAIT, ST_RMW_W,
    ST_PRE, ST_CBR_C, ST_CBR_R
  } dramx4_state_t;

  localparam int CNT_W = 17;
  localparam int ROW_W = dramx4_pkg::PIN_W;
  localparam logic [CNT_W-1:0] REF_INT = ROWS_4K_MODE ?
    CNT_W'(dramx4_pkg::REF_INT_4K) : CNT_W'(dramx4_pkg::REF_INT_2K);

  dramx4_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] refCnt_r;
  logic [3:0] initCnt_r;
  logic refPend_r, lastCbr_r;
  dramx4_pkg::dramx4_req_t req_r;
  logic [dramx4_pkg::DATA_W-1:0] dqSync1_r, dqSync2_r;
  dramx4_pkg::dramx4_pins_t pins_r, pins_nxt;
  logic dqOe_r, dqOe_nxt;
  logic rdValid_r, rdValid_nxt;
  logic [dramx4_pkg::DATA_W-1:0] rdData_r;

  ////////////////////////////////////////////////////////////////////////
  // Address split
  function automatic logic [ROW_W-1:0] rowOf(
    input logic [dramx4_pkg::ADDR_W-1:0] a
  );
    return ROWS_4K_MODE ? a[21:10] : {1'b0, a[21:11]};
  endfunction
  function automatic logic [ROW_W-1:0] colOf(
    input logic [dramx4_pkg::ADDR_W-1:0] a
  );
    return ROWS_4K_MODE ? {2'b00, a[9:0]} : {1'b0, a[10:0]};
  endfunction
  wire [ROW_W-1:0] rowAddr = rowOf(req_r.addr);
  wire [ROW_W-1:0] colAddr = colOf(req_r.addr);
  wire cntDone = (cnt_r == '0);
  wire refDue = (refCnt_r == '0);
  wire takeReq = reqValid && (state_r == ST_IDLE) && !refPend_r;
  wire isWrite = (req_r.op == dramx4_pkg::DRX_OP_WRITE);
  wire isRmw = (req_r.op == dramx4_pkg::DRX_OP_RMW);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cntDone ? '0 : cnt_r - CNT_W'(1);
    pins_nxt = pins_r;
    dqOe_nxt = 1'b0;
    rdValid_nxt = 1'b0;
    case (state_r)
      ST_POWERUP: begin
        if (cntDone) begin
          state_nxt = ST_CBR_C;
        end
      end
      ST_IDLE: begin
        // Row of the incoming request, so it stands before the row strobe
        pins_nxt.addr = rowOf(reqData.addr);
        if (refPend_r) begin
          state_nxt = ST_CBR_C;
        end else if (reqValid) begin
          state_nxt = ST_ROW;
        end
      end
      ST_ROW: begin
        // Row address has stood on the pins since the take edge
        pins_nxt.rasN = 1'b0;
        pins_nxt.wN = !isWrite;
        pins_nxt.oeN = isWrite || isRmw ? isWrite : 1'b0;
        dqOe_nxt = isWrite;
        cnt_nxt = CNT_W'(dramx4_pkg::ROW_COL_CYC);
        state_nxt = ST_COL;
      end
      ST_COL: begin
        // Column follows a cycle after the row strobe, giving row hold
        pins_nxt.addr = colAddr;
        dqOe_nxt = isWrite;
        if (cntDone) begin
          pins_nxt.casN = 1'b0;
          cnt_nxt = CNT_W'(dramx4_pkg::ACCESS_CYC + 2);
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        dqOe_nxt = isWrite;
        if (cntDone) begin
          if (!isWrite) begin
            rdValid_nxt = 1'b1;
          end
          if (isRmw) begin
            pins_nxt.oeN = 1'b1;
            state_nxt = ST_RMW_W;
          end else begin
            // One column per opened row keeps the row low time short
            state_nxt = ST_PRE;
            pins_nxt.rasN = 1'b1;
            pins_nxt.casN = 1'b1;
            pins_nxt.wN = 1'b1;
            pins_nxt.oeN = 1'b1;
            cnt_nxt = CNT_W'(dramx4_pkg::ROW_PRE_CYC);
          end
        end
      end
      ST_RMW_W: begin
        // Data driven first, write select falls a cycle later
        dqOe_nxt = 1'b1;
        if (dqOe_r && pins_r.wN) begin
          pins_nxt.wN = 1'b0;
          cnt_nxt = CNT_W'(dramx4_pkg::ROW_COL_CYC);
        end else if (!pins_r.wN && cntDone) begin
          pins_nxt.rasN = 1'b1;
          pins_nxt.casN = 1'b1;
          pins_nxt.wN = 1'b1;
          dqOe_nxt = 1'b0;
          cnt_nxt = CNT_W'(dramx4_pkg::ROW_PRE_CYC);
          state_nxt = ST_PRE;
        end
      end
      ST_PRE: begin
        if (cntDone) begin
          // Column strobe may stay low between column-first refreshes
          pins_nxt.casN = !(lastCbr_r && refPend_r);
          state_nxt = ST_IDLE;
        end
      end
      ST_CBR_C: begin
        // No row-only or hidden refresh is issued
        pins_nxt.casN = 1'b0;
        pins_nxt.wN = 1'b1;
        pins_nxt.oeN = 1'b1;
        cnt_nxt = CNT_W'(1);
        state_nxt = ST_CBR_R;
      end
      ST_CBR_R: begin
        // Column held low while row is low; the device counts rows
        if (pins_r.rasN && cntDone) begin
          pins_nxt.rasN = 1'b0;
          cnt_nxt = CNT_W'(dramx4_pkg::ROW_ACT_CYC);
        end else if (!pins_r.rasN && cntDone) begin
          pins_nxt.rasN = 1'b1;
          cnt_nxt = CNT_W'(dramx4_pkg::ROW_PRE_CYC);
          state_nxt = ST_PRE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_POWERUP;
      cnt_r <= CNT_W'(POWERUP_CYCLES);
      pins_r <= '{rasN: 1'b1, casN: 1'b1, wN: 1'b1, oeN: 1'b1, addr: '0};
      dqOe_r <= 1'b0;
      rdValid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pins_r <= pins_nxt;
      dqOe_r <= dqOe_nxt;
      rdValid_r <= rdValid_nxt;
    end
  end

  // Refresh scheduler: one column-first cycle per interval; init runs
  // eight of them, each a refresh, before requests are accepted
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refCnt_r <= '0;
      refPend_r <= 1'b0;
      initCnt_r <= '0;
      lastCbr_r <= 1'b0;
    end else begin
      // Reload one short: the period is then the interval, not one more
      refCnt_r <= refDue ? REF_INT - CNT_W'(1)
        : refCnt_r - CNT_W'(1);
      if (state_r == ST_CBR_C) begin
        lastCbr_r <= 1'b1;
        if (initCnt_r < 4'(dramx4_pkg::INIT_CYCLES)) begin
          initCnt_r <= initCnt_r + 4'd1;
        end
      end else if (state_r == ST_ROW) begin
        lastCbr_r <= 1'b0;
      end
      // A new due tick wins over the clear of the pending flag
      if ((refDue && state_r != ST_POWERUP) ||
          (state_r == ST_CBR_C &&
           initCnt_r < 4'(dramx4_pkg::INIT_CYCLES - 1))) begin
        refPend_r <= 1'b1;
      end else if (state_r == ST_CBR_C) begin
        refPend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_r <= '0;
      dqSync1_r <= '0;
      dqSync2_r <= '0;
      rdData_r <= '0;
    end else begin
      if (takeReq) begin
        req_r <= reqData;
      end
      dqSync1_r <= dqIn;
      dqSync2_r <= dqSync1_r;
      if (rdValid_nxt) begin
        rdData_r <= dqSync2_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic reqReady_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reqReady_r <= 1'b0;
    end else begin
      reqReady_r <= (state_nxt == ST_IDLE) &&
        !(refPend_r || (refDue && state_r != ST_POWERUP));
    end
  end
  logic initDone_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      initDone_r <= 1'b0;
    end else if (initCnt_r == 4'(dramx4_pkg::INIT_CYCLES)) begin
      initDone_r <= 1'b1;
    end
  end

  assign reqReady = reqReady_r;
  assign rdData = rdData_r;
  assign rdValid = rdValid_r;
  assign initDone = initDone_r;
  assign pinOut = pins_r;
  assign dqOut = req_r.wdata;
  assign dqOe = dqOe_r;

  ////////////////////////////////////////////////////////////////////////
  AST_CBR_ORDER: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(pins_r.rasN) && state_r == ST_CBR_R |-> !pins_r.casN)
    else $error("Row strobe fell in refresh without column low");
  AST_ROW_ONLY_CAS: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(pins_r.casN) && state_r == ST_WAIT |-> !pins_r.rasN)
    else $error("Column strobe fell without an open row");
  AST_EARLY_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(pins_r.casN) && isWrite && state_r == ST_WAIT |->
      !pins_r.wN && pins_r.oeN)
    else $error("Early write select not ahead of column strobe");
  AST_GATE_FLOAT: assert property (@(posedge clk) disable iff (sys_rst)
    dqOe_r |-> pins_r.oeN)
    else $error("Data driven while output gate active");
  AST_ADDR_STABLE: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(pins_r.rasN) && state_r == ST_COL |-> $stable(pins_r.addr) ##0
      $past(pins_r.addr) == rowAddr)
    else $error("Row address changed at row strobe");
  AST_READ_TIME: assert property (@(posedge clk) disable iff (sys_rst)
    rdValid_r |-> !$past(pins_r.casN) && !$past(pins_r.casN, 4))
    else $error("Read data taken before access time");
  AST_INIT_GATE: assert property (@(posedge clk) disable iff (sys_rst)
    reqReady_r |-> initCnt_r == 4'(dramx4_pkg::INIT_CYCLES))
    else $error("Request accepted before initialisation");
  AST_PRECHARGE: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(pins_r.rasN) |=> pins_r.rasN [*2])
    else $error("Row precharge too short");
  COV_READ: cover property (@(posedge clk) rdValid_r && !isRmw);
  COV_WRITE: cover property (@(posedge clk) $fell(pins_r.wN) && isWrite);
  COV_RMW: cover property (@(posedge clk) state_r == ST_RMW_W && !pins_r.wN);
  COV_CBR_BACK: cover property (@(posedge clk)
    state_r == ST_CBR_C && !pins_r.casN);
endmodule // dramx4_ctrl

/* File: sim/dramx4_mem_model.sv */
// Behavioural page-mode DRAM as seen at the controller's pins.
// Resolves the shared data lines itself and returns the result on busLevel.
`timescale 1ns/10ps
module dramx4_mem_model #(
  parameter bit ROWS_4K_MODE = 1'b1
) (
  input wire logic clk,
  input wire dramx4_pkg::dramx4_pins_t pins,
  input wire logic [3:0] hostData,
  input wire logic hostOe,
  output logic [3:0] busLevel,
  output int refCnt,
  output int refRow,
  output logic [11:0] lastRow,
  output logic [10:0] lastCol,
  output int conflicts
);
  logic [3:0] mem [int];
  logic [3:0] floatVal = 4'h5;
  logic armed = 1'b0;
  logic devDrive;
  int rows;
  function automatic int key(logic [11:0] r, logic [11:0] c);
    return ROWS_4K_MODE ? {r, c[9:0]} : {r[10:0], c[10:0]};
  endfunction
  initial begin
    refCnt = 0;
    refRow = 0;
    conflicts = 0;
  end
  assign rows = ROWS_4K_MODE ? dramx4_pkg::ROWS_4K : dramx4_pkg::ROWS_2K;
  ////////////////////////////////////////////////////////////////////////////
  // Column already low at row fall: internal row, address ignored
  always @(negedge pins.rasN) begin
    if (pins.casN) begin
      lastRow = pins.addr;
    end else begin
      refCnt++;
      refRow = (refRow + 1) % rows;
    end
  end
  always @(negedge pins.casN) begin
    if (!pins.rasN) begin
      lastCol = pins.addr[10:0];
      armed = pins.wN;
      if (!pins.wN) begin
        mem[key(lastRow, pins.addr)] = busLevel;
      end
    end
  end
  always @(negedge pins.wN) begin
    if (!pins.casN && !pins.rasN) begin
      mem[key(lastRow, {1'b0, lastCol})] = busLevel;
    end
  end
  always @(posedge pins.casN) armed = 1'b0;
  assign devDrive = armed && !pins.casN && !pins.oeN && pins.wN;
  // Output is not latched; a floating line shows a changing pattern
  always @* begin
    if (hostOe) begin
      busLevel = hostData;
    end else if (devDrive) begin
      busLevel = mem[key(lastRow, {1'b0, lastCol})];
    end else begin
      busLevel = floatVal;
    end
  end
  always @(posedge clk) begin
    floatVal <= ~floatVal;
    if (hostOe && devDrive) begin
      conflicts <= conflicts + 1;
    end
  end
endmodule // dramx4_mem_model

/* File: sim/testbench.sv */
// Self-checking bench: controller against the behavioural DRAM.
// Runs both geometries in lockstep with a shortened power-up pause.
`timescale 1ns/10ps
module testbench;
  localparam int LIMIT = 5000;
  localparam logic [21:0] ADR_A = 22'h15_0155;
  localparam logic [21:0] ADR_B = 22'h3F_FFFF;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  dramx4_pkg::dramx4_req_t reqData = '0;
  logic reqValid = 1'b0;
  logic reqReady, rdValid, initDone, dqOe;
  logic [3:0] rdData, dqOut, busLevel, got;
  dramx4_pkg::dramx4_pins_t pinOut;
  int refCnt, refRow, conflicts, base;
  logic [11:0] lastRow;
  logic [10:0] lastCol;
  logic reqReady2k, rdValid2k, initDone2k, dqOe2k;
  logic [3:0] rdData2k, dqOut2k, busLevel2k;
  dramx4_pkg::dramx4_pins_t pinOut2k;
  int refCnt2k, refRow2k, conflicts2k;
  logic [11:0] lastRow2k;
  logic [10:0] lastCol2k;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  initial begin
    forever #25 clk = ~clk;
  end
  dramx4_ctrl #(.ROWS_4K_MODE(1'b1), .POWERUP_CYCLES(20)) i_dut (
    .clk(clk), .sys_rst(sysRst), .reqData(reqData), .reqValid(reqValid),
    .reqReady(reqReady), .rdData(rdData), .rdValid(rdValid),
    .initDone(initDone), .pinOut(pinOut), .dqOut(dqOut), .dqOe(dqOe),
    .dqIn(busLevel));
  dramx4_mem_model #(.ROWS_4K_MODE(1'b1)) i_mem (
    .clk(clk), .pins(pinOut), .hostData(dqOut), .hostOe(dqOe),
    .busLevel(busLevel), .refCnt(refCnt), .refRow(refRow),
    .lastRow(lastRow), .lastCol(lastCol), .conflicts(conflicts));
  // Second geometry takes the same requests on the same cycles
  dramx4_ctrl #(.ROWS_4K_MODE(1'b0), .POWERUP_CYCLES(20)) i_dut_2k (
    .clk(clk), .sys_rst(sysRst), .reqData(reqData), .reqValid(reqValid),
    .reqReady(reqReady2k), .rdData(rdData2k), .rdValid(rdValid2k),
    .initDone(initDone2k), .pinOut(pinOut2k), .dqOut(dqOut2k),
    .dqOe(dqOe2k), .dqIn(busLevel2k));
  dramx4_mem_model #(.ROWS_4K_MODE(1'b0)) i_mem_2k (
    .clk(clk), .pins(pinOut2k), .hostData(dqOut2k), .hostOe(dqOe2k),
    .busLevel(busLevel2k), .refCnt(refCnt2k), .refRow(refRow2k),
    .lastRow(lastRow2k), .lastCol(lastCol2k), .conflicts(conflicts2k));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Request held until the edge that sees reqReady high
  task automatic request(input dramx4_pkg::dramx4_op_t op,
                         input logic [21:0] addr, input logic [3:0] wdata,
                         output logic [3:0] rd);
    int n;
    n = 0;
    rd = 'x;
    @(negedge clk);
    reqData = '{op: op, addr: addr, wdata: wdata};
    reqValid = 1'b1;
    while (reqReady !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    reqValid = 1'b0;
    chk("request taken", 1, n < 200);
    n = 0;
    // A write has no answer; it is over once the controller is ready again
    while (n < 40 && (op == dramx4_pkg::DRX_OP_WRITE ? reqReady !== 1'b1 :
                      rdValid !== 1'b1)) begin
      @(negedge clk);
      n++;
    end
    chk("request answered", 1, n < 40);
    chk("lockstep 2k", {reqReady, rdValid}, {reqReady2k, rdValid2k});
    rd = rdData;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_init();
    int n;
    n = 0;
    while (initDone !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk("init done", 1, n < 2000);
    chk("init done 2k", 1, initDone2k);
    // The last init refresh drops its row strobe just after initDone rises
    repeat (4) @(negedge clk);
    chk("init refreshes", dramx4_pkg::INIT_CYCLES, refCnt);
    chk("refresh row", dramx4_pkg::INIT_CYCLES, refRow);
    chk("refresh row 2k", dramx4_pkg::INIT_CYCLES, refRow2k);
    $display("test_init finished");
  endtask
  task automatic test_write_read();
    request(dramx4_pkg::DRX_OP_WRITE, ADR_A, 4'h5, got);
    chk("row lines", ADR_A[21:10], lastRow);
    chk("column lines", ADR_A[9:0], lastCol);
    chk("row lines 2k", ADR_A[21:11], lastRow2k);
    chk("column lines 2k", ADR_A[10:0], lastCol2k);
    request(dramx4_pkg::DRX_OP_WRITE, ADR_B, 4'hA, got);
    request(dramx4_pkg::DRX_OP_READ, ADR_A, 4'h0, got);
    chk("read A", 4'h5, got);
    chk("read A 2k", 4'h5, rdData2k);
    request(dramx4_pkg::DRX_OP_READ, ADR_B, 4'h0, got);
    chk("read B", 4'hA, got);
    chk("read B 2k", 4'hA, rdData2k);
    chk("column lines max", ADR_B[9:0], lastCol);
    $display("test_write_read finished");
  endtask
  task automatic test_rmw();
    request(dramx4_pkg::DRX_OP_RMW, ADR_A, 4'h3, got);
    chk("rmw old data", 4'h5, got);
    chk("rmw old data 2k", 4'h5, rdData2k);
    request(dramx4_pkg::DRX_OP_READ, ADR_A, 4'h0, got);
    chk("rmw new data", 4'h3, got);
    chk("rmw new data 2k", 4'h3, rdData2k);
    chk("bus conflicts", 0, conflicts);
    chk("bus conflicts 2k", 0, conflicts2k);
    $display("test_rmw finished");
  endtask
  // Fixed wait spans two refresh intervals of the 4096-row geometry
  task automatic test_refresh();
    base = refCnt;
    repeat (2 * dramx4_pkg::REF_INT_4K + 40) @(negedge clk);
    chk("periodic refresh", 1, refCnt - base >= 2);
    chk("refresh not excessive", 1, refCnt - base <= 3);
    chk("refresh count 2k", refCnt, refCnt2k);
    $display("test_refresh finished");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      $display("BAD watchdog expected finish seen hang");
      conclude();
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    sysRst = 1'b0;
    test_init();
    test_write_read();
    test_rmw();
    test_refresh();
    conclude();
  end
endmodule // testbench
